// ---- rtl/hmi_regs.sv ----
// What this block does
// - Energy integrates over a window: code 00 128 ms, 01 64 ms, 10 32 ms.
// - A window over half the peak power period becomes the largest compliant window, or 32 ms if none fits.
// - Mode bit 0 counts boost converter pulses per window.
// - Mode bit 1 scales each window count by an efficiency factor.
// - Energy monitor runs only while its enable bit is 1; resets to 0.
// - Interrupt enable holds one bit per source, bit 5 down to bit 0.
// - Events: new monitor data, temperature, source low, overcharge, overdischarge crossings, serial ready rising.
// - A flag sets on its event only if its enable is already set.
// - Enabled interrupt events reach the host on a dedicated pin.
// - Load bit 0 uses pin configuration; writing 1 loads serial registers.
// - Copy busy flag stays 1 while the copy runs, then returns to 0.
// - Status bit 6 shows battery charging enabled.
// - Status bit 4 shows temperature outside the cold to hot range.
// - Status bit 3 is 0 while source is above sleep threshold, else 1.
// - Status bit 2 shows battery above the overcharge level.
// - Status bit 1 shows battery below the overdischarge level.
// - Counter mode gives a 24-bit count over three registers, low byte first.
// - Energy mode gives a 20-bit mantissa with a 4-bit shift in the top nibble.
// - Temperature register holds the 8-bit thermistor divider sample.
// - Battery register holds the 8-bit battery voltage sample.
// - Source register holds the six-bit regulation level code.
// - Battery sampling interval: 000 1.024 s down to 100 64 ms.
`timescale 1ns/1ns
`include "hmi_cfg.svh"
module hmi_regs
	import hmi_pkg::*;
#(
	parameter int MS_CYC = `HMI_MS_CYC,
	parameter int COPY_CYC = `HMI_COPY_CYC,
	parameter logic [7:0] EFF_FACTOR = 8'h01
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire hmi_req_s req,
	output logic [7:0] rdata,
	output logic rvalid,
	input wire logic boost_pulse,
	input wire hmi_stat_s stat,
	input wire logic serial_rdy,
	input wire logic [15:0] peak_power_tracking_period_ms,
	input wire logic [3:0] pin_em_cfg,
	input wire logic [2:0] pin_adc_rate,
	input wire logic [7:0] temp_code,
	input wire logic [7:0] batt_code,
	input wire logic [5:0] src_code,
	output logic irq,
	output logic cfg_serial,
	output logic copy_busy,
	output logic batt_sample
);
	// ****************
	// Result packing
	// ****************
	function automatic logic [23:0] hmi_pack(input logic [31:0] p);
		logic [31:0] m;
		logic [3:0] sh;
		m = p;
		sh = 4'h0;
		for (int i = 0; i < 12; i++) begin
			if (m[31:20] != 12'h000) begin
				m = m >> 1;
				sh = sh + 4'h1;
			end
		end
		return {sh, m[19:0]};
	endfunction

	// ****************
	// Register access
	// ****************
	logic [3:0] em_r;
	logic [5:0] ien_r;
	logic [2:0] adc_r;
	logic [3:0] em_act_r;
	logic [2:0] adc_act_r;
	logic load_r;
	logic [5:0] flg_r;
	logic [5:0] flg_nxt;
	logic [23:0] res_r;
	logic [7:0] rdata_r;
	logic rvalid_r;
	hmi_copy_e cp_r;
	logic [7:0] cp_cnt_r;
	wire wr_em = req.wr && (req.addr == `HMI_OFS_EM);
	wire wr_ien = req.wr && (req.addr == `HMI_OFS_IEN);
	wire wr_adc = req.wr && (req.addr == `HMI_OFS_ADC);
	wire wr_ctrl = req.wr && (req.addr == `HMI_OFS_CTRL);
	wire rd_flg = req.rd && (req.addr == `HMI_OFS_FLG);
	wire [7:0] stat_v = {1'b0, stat.charge_en, 1'b0, stat.temp_out,
		stat.src_low, stat.ovch, stat.ovdis, 1'b0};
	logic [7:0] rd_mux;
	always_comb begin
		if (req.addr == `HMI_OFS_ADC) rd_mux = {5'h00, adc_r};
		else if (req.addr == `HMI_OFS_EM) rd_mux = {4'h0, em_r};
		else if (req.addr == `HMI_OFS_IEN) rd_mux = {2'h0, ien_r};
		else if (req.addr == `HMI_OFS_CTRL) rd_mux = {5'h00, cp_r == CP_BUSY, 1'b0, load_r};
		else if (req.addr == `HMI_OFS_FLG) rd_mux = {2'h0, flg_r};
		else if (req.addr == `HMI_OFS_STAT) rd_mux = stat_v;
		else if (req.addr == `HMI_OFS_RES0) rd_mux = res_r[7:0];
		else if (req.addr == `HMI_OFS_RES1) rd_mux = res_r[15:8];
		else if (req.addr == `HMI_OFS_RES2) rd_mux = res_r[23:16];
		else if (req.addr == `HMI_OFS_TEMP) rd_mux = temp_code;
		else if (req.addr == `HMI_OFS_BATT) rd_mux = batt_code;
		else if (req.addr == `HMI_OFS_SRC) rd_mux = {2'h0, src_code};
		else rd_mux = 8'h00;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			em_r <= `HMI_RST_EM;
			ien_r <= `HMI_RST_IEN;
			adc_r <= `HMI_RST_ADC;
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			if (wr_em) em_r <= req.wdata[3:0];
			if (wr_ien) ien_r <= req.wdata[5:0];
			if (wr_adc) adc_r <= req.wdata[2:0];
			rvalid_r <= req.rd;
			if (req.rd) rdata_r <= rd_mux;
		end
	end
	assign rdata = rdata_r;
	assign rvalid = rvalid_r;

	// ****************
	// Configuration load
	// ****************
	wire [3:0] em_use = load_r ? em_act_r : pin_em_cfg;
	wire [2:0] adc_use = load_r ? adc_act_r : pin_adc_rate;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			load_r <= 1'b0;
			cp_r <= CP_IDLE;
			cp_cnt_r <= 8'h00;
			em_act_r <= `HMI_RST_EM;
			adc_act_r <= `HMI_RST_ADC;
		end else begin
			if (wr_ctrl) load_r <= req.wdata[`HMI_CTRL_LOAD];
			case (cp_r)
				CP_IDLE: begin
					if (wr_ctrl && req.wdata[`HMI_CTRL_LOAD]) begin
						cp_r <= CP_BUSY;
						cp_cnt_r <= 8'(COPY_CYC - 1);
					end
				end
				CP_BUSY: begin
					if (cp_cnt_r == 8'h00) begin
						em_act_r <= em_r;
						adc_act_r <= adc_r;
						cp_r <= CP_IDLE;
					end else begin
						cp_cnt_r <= cp_cnt_r - 8'h01;
					end
				end
				default: cp_r <= CP_IDLE;
			endcase
		end
	end
	assign cfg_serial = load_r;
	assign copy_busy = (cp_r == CP_BUSY);

	// ****************
	// Millisecond tick
	// ****************
	logic [31:0] ms_cnt_r;
	logic ms_tick_r;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ms_cnt_r <= 32'h0;
			ms_tick_r <= 1'b0;
		end else begin
			ms_tick_r <= (ms_cnt_r == 32'(MS_CYC - 1));
			ms_cnt_r <= (ms_cnt_r == 32'(MS_CYC - 1)) ? 32'h0 : ms_cnt_r + 32'h1;
		end
	end

	// ****************
	// Energy monitor
	// ****************
	wire [1:0] win_code = em_use[`HMI_EM_WIN +: 2];
	wire [7:0] win_sel = (win_code == 2'b01) ? 8'(`HMI_WIN01_MS) :
		(win_code == 2'b10) ? 8'(`HMI_WIN10_MS) : 8'(`HMI_WIN00_MS);
	wire [7:0] win_fit = ({8'h00, win_sel, 1'b0} <= {1'b0, peak_power_tracking_period_ms}) ? win_sel :
		(17'(2 * `HMI_WIN00_MS) <= {1'b0, peak_power_tracking_period_ms}) ? 8'(`HMI_WIN00_MS) :
		(17'(2 * `HMI_WIN01_MS) <= {1'b0, peak_power_tracking_period_ms}) ? 8'(`HMI_WIN01_MS) :
		8'(`HMI_WIN10_MS);
	wire em_on = em_use[`HMI_EM_EN];
	logic [7:0] win_cnt_r;
	logic [23:0] pls_cnt_r;
	logic done_r;
	wire win_end = em_on && ms_tick_r && (win_cnt_r >= win_fit - 8'h01);
	wire [23:0] pls_now = pls_cnt_r + {23'h0, boost_pulse};
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			win_cnt_r <= 8'h00;
			pls_cnt_r <= 24'h0;
			res_r <= 24'h0;
			done_r <= 1'b0;
		end else begin
			done_r <= win_end;
			if (!em_on) begin
				win_cnt_r <= 8'h00;
				pls_cnt_r <= 24'h0;
			end else if (win_end) begin
				win_cnt_r <= 8'h00;
				pls_cnt_r <= 24'h0;
				if (em_use[`HMI_EM_MODE]) res_r <= hmi_pack(pls_now * 32'(EFF_FACTOR));
				else res_r <= pls_now;
			end else begin
				pls_cnt_r <= pls_now;
				if (ms_tick_r) win_cnt_r <= win_cnt_r + 8'h01;
			end
		end
	end

	// ****************
	// Battery sampling
	// ****************
	wire [10:0] adc_ms = (adc_use > 3'd4) ? 11'(`HMI_ADC100_MS) :
		11'(`HMI_ADC000_MS) >> adc_use;
	logic [10:0] adc_cnt_r;
	logic smp_r;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			adc_cnt_r <= 11'h000;
			smp_r <= 1'b0;
		end else begin
			smp_r <= 1'b0;
			if (ms_tick_r) begin
				if (adc_cnt_r >= adc_ms - 11'h001) begin
					adc_cnt_r <= 11'h000;
					smp_r <= 1'b1;
				end else begin
					adc_cnt_r <= adc_cnt_r + 11'h001;
				end
			end
		end
	end
	assign batt_sample = smp_r;

	// ****************
	// Interrupt flags
	// ****************
	logic [4:0] st_q_r;
	logic rdy_q_r;
	logic irq_r;
	wire [4:0] st_now = {stat.ovdis, stat.ovch, stat.src_low, stat.temp_out, 1'b0};
	wire [4:0] st_chg = st_now ^ st_q_r;
	wire [5:0] evt = {done_r, st_chg[1], st_chg[2], st_chg[3], st_chg[4],
		serial_rdy & ~rdy_q_r};
	assign flg_nxt = (flg_r & ~{6{rd_flg}}) | (evt & ien_r);
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_q_r <= st_now;
			rdy_q_r <= 1'b0;
			flg_r <= 6'h00;
			irq_r <= 1'b0;
		end else begin
			st_q_r <= st_now;
			rdy_q_r <= serial_rdy;
			flg_r <= flg_nxt;
			irq_r <= |(flg_r & ien_r);
		end
	end
	assign irq = irq_r;

	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_load_wr;
		wr_ctrl && req.wdata[`HMI_CTRL_LOAD] && !copy_busy;
	endsequence
	sequence s_copy_end;
		##[1:64] !copy_busy;
	endsequence
	a_irq_pin_level: assert property (##1 irq == $past(|(flg_r & ien_r)))
		else $error("irq pin does not follow enabled flags");
	a_flag_set_gate: assert property ((evt[`HMI_IRQ_DONE] && ien_r[`HMI_IRQ_DONE]) |=> flg_r[`HMI_IRQ_DONE])
		else $error("enabled event did not set flag");
	a_flag_no_set: assert property ((!ien_r[`HMI_IRQ_OVCH] && !flg_r[`HMI_IRQ_OVCH]) |=> !flg_r[`HMI_IRQ_OVCH])
		else $error("disabled source set a flag");
	a_flag_read_clr: assert property ((rd_flg && ((evt & ien_r) == 6'h00)) |=> flg_r == 6'h00)
		else $error("flag read did not clear");
	a_copy_busy_run: assert property (s_load_wr |=> copy_busy ##0 s_copy_end)
		else $error("copy busy not raised or never ended");
	a_copy_loads_cfg: assert property ($fell(copy_busy) |-> em_act_r == $past(em_r))
		else $error("copy did not load serial settings");
	a_mon_off_idle: assert property (!em_on |=> pls_cnt_r == 24'h0 && win_cnt_r == 8'h00)
		else $error("monitor ran while disabled");
	a_win_fit_rule: assert property ({1'b0, win_fit, 1'b0} <= {1'b0, peak_power_tracking_period_ms} ||
		win_fit == 8'(`HMI_WIN10_MS))
		else $error("window longer than half the period");
	a_stat_read_val: assert property ((req.rd && req.addr == `HMI_OFS_STAT) |=> rvalid &&
		rdata[`HMI_ST_CHARGE] == $past(stat.charge_en) && rdata[`HMI_ST_TEMP] == $past(stat.temp_out))
		else $error("status read mismatch");
	a_ready_flag: assert property ((serial_rdy && !rdy_q_r && ien_r[`HMI_IRQ_RDY]) |-> ##2 irq)
		else $error("serial ready did not raise irq");
	a_flag_hold: assert property (!rd_flg |=> (flg_r & $past(flg_r)) == $past(flg_r))
		else $error("flag dropped without a read");
	a_ien_write: assert property (wr_ien |=> ien_r == $past(req.wdata[5:0]))
		else $error("enable write not stored");
	a_mon_off_done: assert property (!em_on |=> !done_r)
		else $error("monitor finished while disabled");
	a_batt_pulse_one: assert property (batt_sample |=> !batt_sample)
		else $error("sampling pulse longer than one cycle");
	a_load_set: assert property ((wr_ctrl && req.wdata[`HMI_CTRL_LOAD]) |=> cfg_serial)
		else $error("load bit not set by write");
	a_load_clear: assert property ((wr_ctrl && !req.wdata[`HMI_CTRL_LOAD]) |=> !cfg_serial)
		else $error("load bit not cleared by write");

	// ****************
	// Read checks
	// ****************
	a_temp_read_val: assert property ((req.rd && req.addr == `HMI_OFS_TEMP) |=> rdata == $past(temp_code))
		else $error("temperature read mismatch");
	a_batt_read_val: assert property ((req.rd && req.addr == `HMI_OFS_BATT) |=> rdata == $past(batt_code))
		else $error("battery read mismatch");
	a_src_read_val: assert property ((req.rd && req.addr == `HMI_OFS_SRC) |=>
		rdata == {2'h0, $past(src_code)})
		else $error("source level read mismatch");
	a_stat_low_bits: assert property ((req.rd && req.addr == `HMI_OFS_STAT) |=>
		rdata[`HMI_ST_SRCLOW] == $past(stat.src_low) && rdata[`HMI_ST_OVCH] == $past(stat.ovch) &&
		rdata[`HMI_ST_OVDIS] == $past(stat.ovdis))
		else $error("status level bits mismatch");
	a_ctrl_busy_read: assert property ((req.rd && req.addr == `HMI_OFS_CTRL) |=>
		rdata[`HMI_CTRL_BUSY] == $past(copy_busy))
		else $error("busy bit read mismatch");

	// ****************
	// Event checks
	// ****************
	a_temp_evt_flag: assert property (($changed(stat.temp_out) && ien_r[`HMI_IRQ_TEMP]) |=>
		flg_r[`HMI_IRQ_TEMP])
		else $error("temperature crossing did not set flag");
	a_src_evt_flag: assert property (($changed(stat.src_low) && ien_r[`HMI_IRQ_SRCLOW]) |=>
		flg_r[`HMI_IRQ_SRCLOW])
		else $error("source crossing did not set flag");
	a_ovch_evt_flag: assert property (($changed(stat.ovch) && ien_r[`HMI_IRQ_OVCH]) |=>
		flg_r[`HMI_IRQ_OVCH])
		else $error("overcharge crossing did not set flag");
	a_ovdis_evt_flag: assert property (($changed(stat.ovdis) && ien_r[`HMI_IRQ_OVDIS]) |=>
		flg_r[`HMI_IRQ_OVDIS])
		else $error("overdischarge crossing did not set flag");
endmodule

// ---- rtl/hmi_cfg.svh ----
`ifndef HMI_CFG_SVH
`define HMI_CFG_SVH
// ****************
// Register offsets
// ****************
`define HMI_OFS_ADC 8'h08
`define HMI_OFS_EM 8'h09
`define HMI_OFS_IEN 8'h0a
`define HMI_OFS_CTRL 8'h0b
`define HMI_OFS_FLG 8'h0c
`define HMI_OFS_STAT 8'h0d
`define HMI_OFS_RES0 8'h0e
`define HMI_OFS_RES1 8'h0f
`define HMI_OFS_RES2 8'h10
`define HMI_OFS_TEMP 8'h11
`define HMI_OFS_BATT 8'h12
`define HMI_OFS_SRC 8'h13
// ****************
// Field positions
// ****************
`define HMI_EM_EN 0
`define HMI_EM_MODE 1
`define HMI_EM_WIN 2
`define HMI_CTRL_LOAD 0
`define HMI_CTRL_BUSY 2
`define HMI_ST_OVDIS 1
`define HMI_ST_OVCH 2
`define HMI_ST_SRCLOW 3
`define HMI_ST_TEMP 4
`define HMI_ST_CHARGE 6
`define HMI_IRQ_RDY 0
`define HMI_IRQ_OVDIS 1
`define HMI_IRQ_OVCH 2
`define HMI_IRQ_SRCLOW 3
`define HMI_IRQ_TEMP 4
`define HMI_IRQ_DONE 5
// ****************
// Reset values
// ****************
`define HMI_RST_EM 4'h0
`define HMI_RST_IEN 6'h01
`define HMI_RST_ADC 3'h0
// ****************
// Timing
// ****************
`define HMI_CLK_HZ 125000000
`define HMI_MS_CYC (`HMI_CLK_HZ / 1000)
`define HMI_WIN00_MS 128
`define HMI_WIN01_MS 64
`define HMI_WIN10_MS 32
`define HMI_ADC000_MS 1024
`define HMI_ADC100_MS 64
`define HMI_COPY_CYC 4
`endif

// ---- rtl/hmi_pkg.sv ----
package hmi_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hmi_req_s;
	typedef struct packed {
		logic charge_en;
		logic temp_out;
		logic src_low;
		logic ovch;
		logic ovdis;
	} hmi_stat_s;
	typedef enum logic [1:0] {
		CP_IDLE = 2'b00,
		CP_BUSY = 2'b01
	} hmi_copy_e;
endpackage

// ---- tb/hmi_host.sv ----
`timescale 1ns/1ns
// ****************
// Host model
// ****************
module hmi_host
	import hmi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic irq,
	input wire logic rvalid,
	input wire logic [7:0] rdata,
	output hmi_req_s req
);
	initial req = '0;
	// Holds off traffic until the pin shows readiness, giving up after 100 cycles
	task automatic wait_ready(output bit ok);
		ok = 1'b0;
		repeat (100) begin
			@(posedge sys_clk);
			#1;
			if (irq === 1'b1) begin
				ok = 1'b1;
				break;
			end
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		#1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge sys_clk);
		#1 req = '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		#1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge sys_clk);
		#1 req = '0;
		v = 8'hxx;
		repeat (4) begin
			if (rvalid === 1'b1) begin
				v = rdata;
				break;
			end
			@(posedge sys_clk);
			#1;
		end
	endtask
endmodule

// ---- tb/tb_hmi_regs.sv ----
`timescale 1ns/1ns
`include "hmi_cfg.svh"
`define CHK(n, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("[ERR] %s exp %0h got %0h", n, e, g); \
	end \
end
module tb_hmi_regs
	import hmi_pkg::*;
;
	localparam int MS = 10;
	localparam int CP = 4;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	hmi_req_s req;
	logic [7:0] rdata;
	logic rvalid;
	logic irq;
	logic cfg_serial;
	logic copy_busy;
	logic batt_sample;
	logic boost_pulse = 1'b1;
	hmi_stat_s stat = '0;
	logic serial_rdy = 1'b1;
	logic [15:0] peak_power_tracking_period_ms = 16'h0100;
	logic [3:0] pin_em_cfg = 4'h0;
	logic [2:0] pin_adc_rate = 3'h0;
	logic [7:0] temp_code = 8'ha5;
	logic [7:0] batt_code = 8'h3c;
	logic [5:0] src_code = 6'h3a;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [7:0] d;
	bit ok;
	hmi_regs #(.MS_CYC(MS), .COPY_CYC(CP), .EFF_FACTOR(8'h03)) hmi_regs_i (.sys_clk(sys_clk), .rst_n(rst_n),
		.req(req), .rdata(rdata), .rvalid(rvalid), .boost_pulse(boost_pulse), .stat(stat),
		.serial_rdy(serial_rdy), .peak_power_tracking_period_ms(peak_power_tracking_period_ms), .pin_em_cfg(pin_em_cfg),
		.pin_adc_rate(pin_adc_rate), .temp_code(temp_code), .batt_code(batt_code), .src_code(src_code),
		.irq(irq), .cfg_serial(cfg_serial), .copy_busy(copy_busy), .batt_sample(batt_sample));
	hmi_host hmi_host_i (.sys_clk(sys_clk), .irq(irq), .rvalid(rvalid), .rdata(rdata), .req(req));
	always #4 sys_clk = ~sys_clk;
	// Pulses on every other cycle so a plain cycle count cannot pass
	always @(posedge sys_clk) #1 boost_pulse = ~boost_pulse;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 90000) begin
			fail_count++;
			$display("[ERR] cycles exp below 90000 got %0d", cycles);
			results();
		end
	end
	// ****************
	// Helpers
	// ****************
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		hmi_host_i.rd(a, d);
		`CHK("rdata", e, d)
	endtask
	task automatic load(input logic [7:0] a, input logic [7:0] v);
		int n;
		hmi_host_i.wr(a, v);
		hmi_host_i.wr(`HMI_OFS_CTRL, 8'h01);
		n = 0;
		while (copy_busy === 1'b1 && n < 50) begin
			n++;
			step(1);
		end
		`CHK("busy_cycles", CP, n)
		`CHK("cfg_serial", 1'b1, cfg_serial)
	endtask
	task automatic mon(input logic [15:0] per, input logic [7:0] cfg, input logic [23:0] e);
		logic [7:0] b0, b1;
		int n;
		step(1);
		peak_power_tracking_period_ms = per;
		load(`HMI_OFS_EM, cfg);
		repeat (3) begin
			step(1);
			n = 0;
			while (irq !== 1'b1 && n < 2000) begin
				n++;
				step(1);
			end
			`CHK("irq", 1'b1, irq)
			hmi_host_i.rd(`HMI_OFS_FLG, d);
			step(3);
		end
		hmi_host_i.rd(`HMI_OFS_RES0, b0);
		hmi_host_i.rd(`HMI_OFS_RES1, b1);
		hmi_host_i.rd(`HMI_OFS_RES2, d);
		`CHK("result", e, {d, b1, b0})
	endtask
	task automatic wpulse(output int n);
		n = 0;
		do begin
			step(1);
			n++;
		end while (batt_sample !== 1'b1 && n < 20000);
	endtask
	task automatic rate(input logic [2:0] c, input int e);
		int n;
		load(`HMI_OFS_ADC, {5'h00, c});
		wpulse(n);
		wpulse(n);
		`CHK("interval", e, n)
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ****************
	// Tests
	// ****************
	initial begin
		repeat (20) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		hmi_host_i.wait_ready(ok);
		`CHK("ready", 1'b1, ok)
		rchk(`HMI_OFS_ADC, 8'h00);
		rchk(`HMI_OFS_EM, 8'h00);
		rchk(`HMI_OFS_IEN, 8'h01);
		rchk(`HMI_OFS_CTRL, 8'h00);
		rchk(`HMI_OFS_FLG, 8'h01);
		step(3);
		`CHK("irq", 1'b0, irq)
		rchk(`HMI_OFS_FLG, 8'h00);
		$display("test reset done");
		hmi_host_i.wr(`HMI_OFS_IEN, 8'h00);
		stat = 5'b10101;
		step(3);
		rchk(`HMI_OFS_STAT, 8'h4a);
		step(1);
		stat = 5'b01010;
		step(3);
		rchk(`HMI_OFS_STAT, 8'h14);
		rchk(`HMI_OFS_FLG, 8'h00);
		hmi_host_i.wr(`HMI_OFS_IEN, 8'h1e);
		step(1);
		stat = 5'b10101;
		step(3);
		`CHK("irq", 1'b1, irq)
		rchk(`HMI_OFS_FLG, 8'h1e);
		step(3);
		`CHK("irq", 1'b0, irq)
		$display("test events done");
		rchk(`HMI_OFS_TEMP, 8'ha5);
		rchk(`HMI_OFS_BATT, 8'h3c);
		rchk(`HMI_OFS_SRC, 8'h3a);
		hmi_host_i.wr(`HMI_OFS_STAT, 8'hff);
		rchk(`HMI_OFS_STAT, 8'h4a);
		rchk(8'h20, 8'h00);
		$display("test readback done");
		hmi_host_i.wr(`HMI_OFS_IEN, 8'h20);
		mon(16'h0064, 8'h01, 24'(16 * MS));
		mon(16'h0100, 8'h05, 24'(32 * MS));
		mon(16'h0100, 8'h09, 24'(16 * MS));
		mon(16'h0064, 8'h03, 24'(16 * MS * 3));
		load(`HMI_OFS_EM, 8'h00);
		step(3);
		hmi_host_i.rd(`HMI_OFS_FLG, d);
		step(1000);
		rchk(`HMI_OFS_FLG, 8'h00);
		$display("test monitor done");
		for (int i = 4; i >= 0; i--) begin
			rate(i[2:0], (1024 >> i) * MS);
		end
		$display("test rate done");
		results();
	end
endmodule
